//--- core/sbbp_port.v
// six-bit bidirectional port with direction and analog config registers
//
// Contract
// - six pins, each with own output latch and own direction bit.
// - direction bit one turns the pin driver off; pin is an input.
// - direction bit zero drives the pin from its latch bit.
// - port reads return pin levels; port writes update the latches.
// - bit set/clear writes are read-modify-write: sample pins, modify, store latch; plain port writes store the data.
// - pin four feeds timer clock input; its output only pulls low.
// - other pins analog or reference; config field picks analog or digital.
// - after reset analog-capable pins are analog and read as zero.
// - pin five is also serial slave select and an analog channel.
// - direction register resets to all six bits set on every reset.
// - unimplemented bits of all three registers read as zero.
// - an enabled timer clock or slave select owns its pin, not general I/O.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "sbbp_defines.vh"

module sbbp_port (
	input  wire                    core_clk,
	input  wire                    rstn,
	input  wire [`SBBP_AW-1:0]     reg_addr,
	input  wire [`SBBP_DW-1:0]     reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [`SBBP_DW-1:0]     reg_rdata,
	input  wire [`SBBP_NPINS-1:0]  pin_in,
	output reg  [`SBBP_NPINS-1:0]  pin_out,
	output reg  [`SBBP_NPINS-1:0]  pin_oe,
	input  wire                    timer_clk_sel,
	input  wire                    ssel_en,
	output reg                     timer_ext_clock_in,
	output reg                     slave_select_n,
	output reg  [`SBBP_NPINS-1:0]  analog_chan_en,
	output reg                     result_justify
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------

	// analog pins for a given pin_config_field value
	function [`SBBP_NPINS-1:0] analog_mask;
		input [`SBBP_CFG_MSB:`SBBP_CFG_LSB] cfg;
		begin
			if (cfg[`SBBP_CFG_MSB:`SBBP_CFG_LSB+1] == `SBBP_CFG_DIG_HI) begin
				analog_mask = `SBBP_NO_ANALOG;
			end else if (cfg == `SBBP_CFG_SS_A || cfg == `SBBP_CFG_SS_B ||
				cfg == `SBBP_CFG_SS_C || cfg == `SBBP_CFG_SS_D ||
				cfg == `SBBP_CFG_SS_E) begin
				analog_mask = `SBBP_LOW_ANALOG; // pin five left digital
			end else begin
				analog_mask = `SBBP_ALL_ANALOG;
			end
		end
	endfunction

	// address match, one place so all write decodes agree
	function hit;
		input [`SBBP_AW-1:0] a;
		input [`SBBP_AW-1:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg  [`SBBP_NPINS-1:0]          latch_r;
	reg  [`SBBP_NPINS-1:0]          latch_nxt;
	reg  [`SBBP_NPINS-1:0]          dir_r;
	reg  [`SBBP_NPINS-1:0]          dir_nxt;
	reg  [`SBBP_CFG_MSB:0]          cfg_r;
	reg  [`SBBP_CFG_MSB:0]          cfg_nxt;
	reg                             just_r;
	reg                             just_nxt;
	reg  [`SBBP_DW-1:0]             rdata_nxt;
	wire [`SBBP_NPINS-1:0]          pin_sync;
	wire [`SBBP_NPINS-1:0]          amask;
	wire [`SBBP_NPINS-1:0]          pin_level;
	wire [`SBBP_NPINS-1:0]          force_in;
	wire [`SBBP_NPINS-1:0]          eff_dir;
	wire [`SBBP_NPINS-1:0]          oe_nxt;
	wire [`SBBP_NPINS-1:0]          out_nxt;
	wire [`SBBP_DW-1:0]             port_view;
	wire [`SBBP_DW-1:0]             dir_view;
	wire [`SBBP_DW-1:0]             cfg_view;
	wire [`SBBP_DW-1:0]             lat_view;
	wire                            wr_port;
	wire                            wr_dir;
	wire                            wr_cfg;
	wire                            wr_bset;
	wire                            wr_bclr;
	genvar                          g;

	// ------------------------------------------------------------
	// pin input synchronisation
	// ------------------------------------------------------------

	// pads are asynchronous to core_clk, so nothing reads them raw
	sbbp_sync #(
		.W        (`SBBP_NPINS)
	) u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	// ------------------------------------------------------------
	// digital view of the pins
	// ------------------------------------------------------------

	// analog pins have their digital buffer off and read as zero
	assign amask = analog_mask(cfg_r);

	// one input buffer per pin, gated while the pin is analog
	generate
		for (g = 0; g < `SBBP_NPINS; g = g + 1) begin : g_dig
			assign pin_level[g] = pin_sync[g] & ~amask[g];
		end
	endgenerate

	// ------------------------------------------------------------
	// pin ownership
	// ------------------------------------------------------------

	// an enabled timer clock or slave select takes its pin: the driver is forced off
	// whatever the direction bit says, so the pin stops being I/O
	generate
		for (g = 0; g < `SBBP_NPINS; g = g + 1) begin : g_own
			if (g == `SBBP_OD_PIN) begin : g_tmr
				assign force_in[g] = timer_clk_sel;
			end else if (g == `SBBP_SS_PIN) begin : g_ssel
				assign force_in[g] = ssel_en;
			end else begin : g_gpio
				assign force_in[g] = 1'b0;
			end
		end
	endgenerate

	// analog use leaves the driver to the direction bit alone
	assign eff_dir = dir_r | force_in;

	// ------------------------------------------------------------
	// register write decode
	// ------------------------------------------------------------
	// one strobe per register; unmapped addresses match none
	assign wr_port = reg_wr && hit(reg_addr, `SBBP_ADDR_PORT);
	assign wr_dir  = reg_wr && hit(reg_addr, `SBBP_ADDR_DIR);
	assign wr_cfg  = reg_wr && hit(reg_addr, `SBBP_ADDR_ACFG);
	assign wr_bset = reg_wr && hit(reg_addr, `SBBP_ADDR_BSET);
	assign wr_bclr = reg_wr && hit(reg_addr, `SBBP_ADDR_BCLR);

	// ------------------------------------------------------------
	// next-state of the registers
	// ------------------------------------------------------------

	// latch: plain write takes the data, set/clear start from pin
	// levels, so an input pin's level is copied into its latch
	always @* begin
		latch_nxt = latch_r;
		if (wr_port) begin
			latch_nxt = reg_wdata[`SBBP_NPINS-1:0];
		end
		if (wr_bset) begin
			latch_nxt = pin_level | reg_wdata[`SBBP_NPINS-1:0];
		end
		if (wr_bclr) begin
			latch_nxt = pin_level & ~reg_wdata[`SBBP_NPINS-1:0];
		end
	end

	// direction: whole-register write only
	always @* begin
		dir_nxt = dir_r;
		if (wr_dir) begin
			dir_nxt = reg_wdata[`SBBP_NPINS-1:0];
		end
	end

	// analog config: field and justify bit, gap bits dropped
	always @* begin
		cfg_nxt  = cfg_r;
		just_nxt = just_r;
		if (wr_cfg) begin
			cfg_nxt  = reg_wdata[`SBBP_CFG_MSB:`SBBP_CFG_LSB];
			just_nxt = reg_wdata[`SBBP_JUST_BIT];
		end
	end

	// ------------------------------------------------------------
	// register flops
	// ------------------------------------------------------------

	// every reset source arrives on rstn; the latch value is ours,
	// harmless since pins stay inputs until direction is cleared
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			latch_r <= `SBBP_LAT_RST;
		end else begin
			latch_r <= latch_nxt;
		end
	end

	// all six pins inputs after any reset
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dir_r <= `SBBP_DIR_RST;
		end else begin
			dir_r <= dir_nxt;
		end
	end

	// config resets to analog on every pin but four, so those pins start isolated
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_r  <= `SBBP_CFG_RST;
			just_r <= `SBBP_JUST_RST;
		end else begin
			cfg_r  <= cfg_nxt;
			just_r <= just_nxt;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------

	// register views padded to bus width; unused bits tie to zero
	assign port_view = {{(`SBBP_DW-`SBBP_NPINS){1'b0}}, pin_level};
	assign dir_view  = {{(`SBBP_DW-`SBBP_NPINS){1'b0}}, dir_r};
	assign cfg_view  = {just_r, {(`SBBP_JUST_BIT-`SBBP_CFG_MSB-1){1'b0}}, cfg_r};
	assign lat_view  = {{(`SBBP_DW-`SBBP_NPINS){1'b0}}, latch_r};

	// data stand one cycle after the strobe and are zero otherwise
	always @* begin
		rdata_nxt = {`SBBP_DW{1'b0}};
		if (reg_rd) begin
			case (reg_addr)
				`SBBP_ADDR_PORT: begin
					rdata_nxt = port_view;
				end
				`SBBP_ADDR_DIR: begin
					rdata_nxt = dir_view;
				end
				`SBBP_ADDR_ACFG: begin
					rdata_nxt = cfg_view;
				end
				`SBBP_ADDR_BSET: begin
					rdata_nxt = lat_view;
				end
				`SBBP_ADDR_BCLR: begin
					rdata_nxt = lat_view;
				end
				default: begin
					rdata_nxt = {`SBBP_DW{1'b0}};
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// pin driver control
	// ------------------------------------------------------------

	// one driver slice per pin; the open-drain slice only sinks
	generate
		for (g = 0; g < `SBBP_NPINS; g = g + 1) begin : g_drv
			if (g == `SBBP_OD_PIN) begin : g_od
				// high level comes from the external pull-up, never from us
				assign oe_nxt[g]  = ~eff_dir[g] & ~latch_r[g];
				assign out_nxt[g] = 1'b0;
			end else begin : g_pp
				// push-pull: direction one floats, zero shows the latch
				assign oe_nxt[g]  = ~eff_dir[g];
				assign out_nxt[g] = latch_r[g];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// output flops
	// ------------------------------------------------------------

	// read data held exactly one cycle, then back to zero
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= {`SBBP_DW{1'b0}};
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	// pad stage registered so pads see clean levels; drivers off in reset
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_out <= {`SBBP_NPINS{1'b0}};
			pin_oe  <= {`SBBP_NPINS{1'b0}};
		end else begin
			pin_out <= out_nxt;
			pin_oe  <= oe_nxt;
		end
	end

	// schmitt buffer is never analog, so pin four is always passed on
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			timer_ext_clock_in <= 1'b0;
		end else begin
			timer_ext_clock_in <= pin_sync[`SBBP_OD_PIN];
		end
	end

	// select idles inactive; an analog pin five reads low and would
	// select us, so software keeps that pin digital while enabled
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			slave_select_n <= 1'b1;
		end else begin
			slave_select_n <= ssel_en ? pin_level[`SBBP_SS_PIN] : 1'b1;
		end
	end

	// analog channel enables for the converter input mux
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			analog_chan_en <= {`SBBP_NPINS{1'b0}};
		end else begin
			analog_chan_en <= amask;
		end
	end

	// result alignment choice handed on to the converter
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			result_justify <= `SBBP_JUST_RST;
		end else begin
			result_justify <= just_r;
		end
	end

endmodule // sbbp_port

//--- core/sbbp_defines.vh
// constants shared by the six-bit port files
`ifndef SBBP_DEFINES_VH
`define SBBP_DEFINES_VH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define SBBP_NPINS        6
`define SBBP_AW           8
`define SBBP_DW           8

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SBBP_ADDR_PORT    8'h05
`define SBBP_ADDR_DIR     8'h85
`define SBBP_ADDR_ACFG    8'h9F
`define SBBP_ADDR_BSET    8'hE5
`define SBBP_ADDR_BCLR    8'hE6

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SBBP_DIR_RST      6'h3F
`define SBBP_LAT_RST      6'h00
`define SBBP_CFG_RST      4'h0
`define SBBP_JUST_RST     1'b0

// ------------------------------------------------------------
// field positions and special pins
// ------------------------------------------------------------
`define SBBP_CFG_MSB      3
`define SBBP_CFG_LSB      0
`define SBBP_JUST_BIT     7
`define SBBP_OD_PIN       4
`define SBBP_SS_PIN       5

// ------------------------------------------------------------
// pin_config_field codes
// ------------------------------------------------------------
`define SBBP_CFG_DIG_HI   3'h3
`define SBBP_CFG_SS_A     4'h4
`define SBBP_CFG_SS_B     4'h5
`define SBBP_CFG_SS_C     4'hD
`define SBBP_CFG_SS_D     4'hE
`define SBBP_CFG_SS_E     4'hF
`define SBBP_ALL_ANALOG   6'h2F
`define SBBP_LOW_ANALOG   6'h0F
`define SBBP_NO_ANALOG    6'h00

`endif

//--- core/sbbp_sync.v
// two-flop synchroniser bank for the port pins
`timescale 1ns/1ns

module sbbp_sync #(
	parameter W = 6
) (
	input  wire         core_clk,
	input  wire         rstn,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	// ------------------------------------------------------------
	// per-bit double flop
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_r;
			reg stable_r;
			// first flop feeds only the second, never any logic
			always @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					meta_r   <= 1'b0;
					stable_r <= 1'b0;
				end else begin
					meta_r   <= async_in[i];
					stable_r <= meta_r;
				end
			end
			assign sync_out[i] = stable_r;
		end
	endgenerate

endmodule // sbbp_sync

//--- testbench/sbbp_checker.sv
// concurrent checks on the six-bit port outputs and register bus
`timescale 1ns/1ns
module sbbp_checker (
	input wire       core_clk,
	input wire       rstn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire [5:0] pin_out,
	input wire [5:0] pin_oe,
	input wire       timer_clk_sel,
	input wire       ssel_en,
	input wire       slave_select_n,
	input wire [5:0] analog_chan_en,
	input wire       result_justify
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// a taken write or read at one address
	sequence s_wr(a); reg_wr && reg_addr == a; endsequence
	sequence s_rd(a); reg_rd && reg_addr == a; endsequence
	// outputs lag a taken write by two edges: register, then pad stage
	od_low_a: assert property (pin_out[4] == 1'b0) else $error("pin four driven high");
	chan_four_a: assert property (analog_chan_en[4] == 1'b0) else $error("pin four analog");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside slot");
	port_top_a: assert property (s_rd(8'h05) or s_rd(8'h85) |=> reg_rdata[7:6] == 2'h0)
		else $error("unused port bits set");
	cfg_mid_a: assert property (s_rd(8'h9F) |=> reg_rdata[6:4] == 3'h0)
		else $error("unused config bits set");
	ss_idle_a: assert property (!ssel_en |=> slave_select_n) else $error("select active");
	ss_owns_a: assert property (ssel_en |=> !pin_oe[5]) else $error("pin five driven");
	tmr_owns_a: assert property (timer_clk_sel |=> !pin_oe[4]) else $error("pin four driven");
	dir_in_a: assert property (s_wr(8'h85) ##0 reg_wdata[0] |-> ##2 !pin_oe[0])
		else $error("input pin driven");
	dir_out_a: assert property (s_wr(8'h85) ##0 !reg_wdata[0] |-> ##2 pin_oe[0])
		else $error("output pin not driven");
	latch_out_a: assert property (s_wr(8'h05) |-> ##2 pin_out[3:0] == $past(reg_wdata[3:0], 2))
		else $error("latch not on pins");
	justify_a: assert property (s_wr(8'h9F) |-> ##2 result_justify == $past(reg_wdata[7], 2))
		else $error("justify bit stale");
endmodule // sbbp_checker

bind sbbp_port sbbp_checker sbbp_checker_i (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .pin_out, .pin_oe, .timer_clk_sel, .ssel_en, .slave_select_n,
	.analog_chan_en, .result_justify);

//--- testbench/sbbp_pads.sv
// pad model: outside drivers meeting the port's drivers
`timescale 1ns/1ns
module sbbp_pads (
	input  wire [5:0] pin_out,
	input  wire [5:0] pin_oe,
	input  wire [5:0] ext_lvl,
	output wire [5:0] pin_in
);
	// driven pad shows the port; pin four only sinks, else the outside level wins
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // sbbp_pads

//--- testbench/testbench.sv
// self-checking bench for the six-bit port
`timescale 1ns/1ns
module testbench;
	logic       core_clk, rstn, reg_wr, reg_rd, timer_clk_sel, ssel_en;
	logic       timer_ext_clock_in, slave_select_n, result_justify;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [5:0] pin_in, pin_out, pin_oe, ext_lvl, analog_chan_en, am, l, o, p;
	int         error_cnt, checked, r, i;
	sbbp_port sbbp_port_i (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .pin_in, .pin_out, .pin_oe, .timer_clk_sel, .ssel_en,
		.timer_ext_clock_in, .slave_select_n, .analog_chan_en, .result_justify);
	sbbp_pads sbbp_pads_i (.pin_out, .pin_oe, .ext_lvl, .pin_in);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bus cycles: one-cycle strobes, read data taken in the slot after
	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= dv;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		rv = reg_rdata;
	endtask
	// analog pins per config code; pin four never analog
	function automatic logic [5:0] amask(input logic [3:0] c);
		if (c[3:1] == 3'h3) return 6'h00;
		if (c == 4'h4 || c == 4'h5 || c > 4'hC) return 6'h0F;
		return 6'h2F;
	endfunction
	task automatic report_and_stop();
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// watchdog, far beyond the roughly eleven hundred cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		{rstn, reg_wr, reg_rd, timer_clk_sel, ssel_en} = 5'h0;
		{reg_addr, reg_wdata} = 16'h0;
		error_cnt = 0;
		checked = 0;
		r = $urandom(32'h0699);
		ext_lvl = r[5:0];
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(8'h85); chk(rv, 8'h3F);
		rd(8'h9F); chk(rv, 8'h00);
		rd(8'h05); chk(rv, {2'h0, ext_lvl & 6'h10});
		chk({2'h0, pin_oe}, 8'h00);
		wr(8'h85, 8'h3F);
		// every config code, with slave select toggled at random
		for (i = 0; i < 16; i++) begin
			r = $urandom;
			am = amask(i[3:0]);
			// select only enabled while pin five is digital
			ssel_en <= r[0] & ~am[5];
			ext_lvl <= r[13:8];
			wr(8'h9F, {r[7], 3'h7, i[3:0]});
			repeat (3) @(posedge core_clk);
			chk({2'h0, analog_chan_en}, {2'h0, am});
			chk({7'h0, slave_select_n}, {7'h0, ~(r[0] & ~am[5]) | ext_lvl[5]});
			rd(8'h9F); chk(rv, {r[7], 3'h0, i[3:0]});
			rd(8'h05); chk(rv, {2'h0, ext_lvl & ~am});
		end
		// all digital; random direction, latch and peripheral ownership
		wr(8'h9F, 8'h06);
		for (i = 0; i < 40; i++) begin
			r = $urandom;
			{ssel_en, timer_clk_sel} <= r[9:8];
			ext_lvl <= r[21:16];
			l = r[15:10];
			if (i == 0) r[5:0] = 6'h00;
			wr(8'h85, r[7:0]);
			wr(8'h05, {r[31:30], l});
			// pads settle one edge after the latch, then two sync edges
			repeat (5) @(posedge core_clk);
			o = ~r[5:0] & ~{ssel_en, timer_clk_sel | l[4], 4'h0};
			p = (o & l & 6'h2F) | (~o & ext_lvl);
			chk({2'h0, pin_oe}, {2'h0, o});
			chk({2'h0, pin_out}, {2'h0, l & 6'h2F});
			chk({7'h0, timer_ext_clock_in}, {7'h0, p[4]});
			rd(8'h05); chk(rv, {2'h0, p});
			rd(8'h85); chk(rv, {2'h0, r[5:0]});
			// set or clear on top of the sampled pin levels
			l = i[0] ? (p | r[29:24]) : (p & ~r[29:24]);
			wr(i[0] ? 8'hE5 : 8'hE6, {2'h0, r[29:24]});
			rd(8'hE5); chk(rv, {2'h0, l});
			repeat (2) @(posedge core_clk);
			chk({2'h0, pin_out}, {2'h0, l & 6'h2F});
		end
		wr(8'h10, 8'hFF);
		rd(8'h10); chk(rv, 8'h00);
		// second reset in mid-run: drivers off, all pins inputs again
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk({2'h0, pin_oe}, 8'h00);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(8'h85); chk(rv, 8'h3F);
		report_and_stop();
	end
endmodule // testbench
